//--- eerd_checker.sv
// Port-level assertions for the memory read path
`timescale 1ns/10ps
module eerd_checker
  import eerd_pkg::*;
(
  input wire logic              clk_sys_i,    // Clock
  input wire logic              sys_rst_i,    // Reset
  input wire logic              scl_i,        // Bus clock
  input wire logic              sda_i,        // Bus data
  input wire logic              sda_o,        // Drive value
  input wire logic              sda_oe_o,     // Data pull
  input wire logic              prog_busy_i,  // Programming
  input wire eerd_fill_s        fill_i,       // Preload word
  input wire logic              fill_valid_i, // Preload valid
  input wire logic              fill_ready_o, // Preload room
  input wire logic [ADDR_W-1:0] addr_ptr_o,   // Pointer
  input wire logic              active_o      // In frame
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  a_rst_clear: assert property ($fell(sys_rst_i) |-> !active_o && fill_ready_o
    && addr_ptr_o == PTR_RESET) else $error("Reset left state behind");
  a_start_wake: assert property (s_start |-> ##[1:6] active_o)
    else $error("Start not taken");
  a_stop_quiet: assert property (s_stop |-> ##[1:6] !active_o)
    else $error("Stop not taken");
  a_idle_silent: assert property (!active_o |-> !sda_oe_o)
    else $error("Data driven outside a frame");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("Data changed outside clock low");
  a_busy_mute: assert property (prog_busy_i [*8] |-> !$rose(sda_oe_o))
    else $error("Acknowledge while programming");
  a_ptr_jump: assert property ($changed(addr_ptr_o) && !prog_busy_i
    && addr_ptr_o != $past(addr_ptr_o) + PTR_STEP |-> ##[0:6] sda_oe_o)
    else $error("Pointer loaded without acknowledge");
  a_ptr_idle: assert property (!active_o [*2] |-> $stable(addr_ptr_o))
    else $error("Pointer moved outside a frame");
endmodule
bind eerd_top eerd_checker chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_busy_i(prog_busy_i),
  .fill_i(fill_i), .fill_valid_i(fill_valid_i), .fill_ready_o(fill_ready_o),
  .addr_ptr_o(addr_ptr_o), .active_o(active_o));

//--- eerd_fifo.sv
// Parameterised valid/ready FIFO with registered full and empty flags
`timescale 1ns/10ps
module eerd_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk_sys_i,   // System clock
  input  wire logic             sys_rst_i,   // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] in_data_i,   // Write data
  input  wire logic             in_valid_i,  // Write request
  output logic                  in_ready_o,  // Room available
  output logic [WIDTH-1:0]      out_data_o,  // Head word
  output logic                  out_valid_o, // Head word present
  input  wire logic             out_ready_i  // Head word taken
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
    logic          full;
    logic          empty;
    logic          room;
  } eerd_fifo_s;

  eerd_fifo_s       st_q;
  eerd_fifo_s       st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             push;
  logic             pop;

  assign push        = in_valid_i && !st_q.full;
  assign pop         = out_ready_i && !st_q.empty;
  assign in_ready_o  = st_q.room;
  assign out_valid_o = !st_q.empty;
  assign out_data_o  = mem_q[st_q.rd];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = (st_q.wr == PW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == PW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
    st_d.full  = (st_d.cnt == (PW+1)'(DEPTH));
    st_d.empty = (st_d.cnt == '0);
    st_d.room  = !st_d.full;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q       <= '0;
      st_q.empty <= 1'b1;
      st_q.room  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_q[st_q.wr] <= in_data_i;
    end
  end
endmodule

//--- eerd_master.sv
// Two-wire bus master model: clock, start, stop, bytes and acks
`timescale 1ns/10ps
module eerd_master (
  input  wire logic clk_sys_i, // System clock
  input  wire logic sda_i,     // Resolved data line
  output logic      scl_o,     // Bus clock
  output logic      pull_o     // High while pulling data low
);
  initial begin
    scl_o <= 1'b1;
    pull_o <= 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // Data set in the low phase, line read late in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_o <= !b;
    wt(6);
    scl_o <= 1'b1;
    wt(9);
    r = sda_i;
    wt(1);
    scl_o <= 1'b0;
    wt(4);
  endtask
  // Start (also repeated) when st is high, stop otherwise
  task automatic cond(input logic st);
    pull_o <= !st;
    wt(6);
    scl_o <= 1'b1;
    wt(8);
    pull_o <= st;
    wt(8);
    if (st) begin
      scl_o <= 1'b0;
      wt(4);
    end
  endtask
  task automatic put(input logic [7:0] v, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, nak);
  endtask
  task automatic get(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(!more, r);
  endtask
endmodule

//--- eerd_pkg.sv
// Shared constants and types for the serial memory read path
package eerd_pkg;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MEM_WORDS  = 128;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0]  CTRL_CODE  = 4'ha;
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [ADDR_W-1:0] PTR_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP  = 7'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    EERD_IDLE  = 3'b000,
    EERD_CTRL  = 3'b001,
    EERD_CACK  = 3'b010,
    EERD_WADDR = 3'b011,
    EERD_WACK  = 3'b100,
    EERD_TX    = 3'b101,
    EERD_RACK  = 3'b110,
    EERD_SKIP  = 3'b111
  } eerd_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eerd_fill_s;

  localparam int unsigned FILL_W = $bits(eerd_fill_s);
endpackage

//--- eerd_top.sv
// Two-wire slave read path of a 128 x 8 serial memory
//
// How it works
// RULE_01 - Read is framed like a write; direction bit one selects read.
// RULE_02 - Pointer holds last accessed location plus one for current address reads.
// RULE_03 - Matching read control byte is acknowledged, then byte at pointer shifts out.
// RULE_04 - Master leaves ack high then stops; device stops driving data.
// RULE_05 - Random read: master writes control and word address, then repeated start.
// RULE_06 - Repeated start after word address abandons write but keeps pointer loaded.
// RULE_07 - After repeated start master resends control byte with direction one.
// RULE_08 - Each master ack after a byte sends the next sequential byte.
// RULE_09 - Pointer advances by one for every byte handled.
// RULE_10 - Seven-bit pointer wraps from 0x7F to 0x00.
// RULE_11 - Only control code 1010 answers; block bits ignored; last bit is direction.
// RULE_12 - No byte is acknowledged while a programming cycle runs.
`timescale 1ns/10ps
module eerd_top
  import eerd_pkg::*;
(
  input  wire logic              clk_sys_i,    // 20 MHz system clock
  input  wire logic              sys_rst_i,    // Synchronous reset, active high
  input  wire logic              scl_i,        // Bus clock pin level
  input  wire logic              sda_i,        // Bus data pin level
  output logic                   sda_o,        // Data pin drive value, always low
  output logic                   sda_oe_o,     // High while pulling data pin low
  input  wire logic              prog_busy_i,  // Programming cycle running
  input  wire eerd_fill_s        fill_i,       // Preload address and byte
  input  wire logic              fill_valid_i, // Preload word present
  output logic                   fill_ready_o, // Preload FIFO has room
  output logic [ADDR_W-1:0]      addr_ptr_o,   // Current address pointer
  output logic                   active_o      // Transaction in progress
);
  typedef struct packed {
    logic [1:0]        scl_sync;
    logic [1:0]        sda_sync;
    logic              scl_prev;
    logic              sda_prev;
    eerd_state_e       state;
    logic [3:0]        cnt;
    logic [DATA_W-1:0] shreg;
    logic [ADDR_W-1:0] ptr;
    logic              rw;
    logic              acked;
    logic              oe;
    logic              act;
  } eerd_top_s;

  eerd_top_s         st_q;
  eerd_top_s         st_d;
  // The array has no reset; it is filled through the preload FIFO
  logic [DATA_W-1:0] mem_q [MEM_WORDS];
  eerd_fill_s        fifo_head;
  logic              fifo_valid;
  logic              fifo_take;
  logic              scl_s;
  logic              sda_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;

  ////////////////////////////////////////////////////////////////////////////
  // Preload path: drained into the array only while the bus is idle
  eerd_fifo #(
    .WIDTH (FILL_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fill_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (fill_i),
    .in_valid_i  (fill_valid_i),
    .in_ready_o  (fill_ready_o),
    .out_data_o  (fifo_head),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_take)
  );

  assign fifo_take = fifo_valid && (st_q.state == EERD_IDLE);

  always_ff @(posedge clk_sys_i) begin
    if (fifo_take) begin
      mem_q[fifo_head.addr] <= fifo_head.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditions, seen only after the second synchroniser stage
  assign scl_s      = st_q.scl_sync[1];
  assign sda_s      = st_q.sda_sync[1];
  assign scl_rise   = scl_s && !st_q.scl_prev;
  assign scl_fall   = !scl_s && st_q.scl_prev;
  assign start_cond = scl_s && st_q.scl_prev && st_q.sda_prev && !sda_s;
  assign stop_cond  = scl_s && st_q.scl_prev && !st_q.sda_prev && sda_s;

  // Open-drain value is fixed low; the other outputs are state register bits
  assign sda_o      = 1'b0;
  assign sda_oe_o   = st_q.oe;
  assign addr_ptr_o = st_q.ptr;
  assign active_o   = st_q.act;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine, stepped on the synchronised pin edges
  always_comb begin
    st_d          = st_q;
    st_d.scl_sync = {st_q.scl_sync[0], scl_i};
    st_d.sda_sync = {st_q.sda_sync[0], sda_i};
    st_d.scl_prev = scl_s;
    st_d.sda_prev = sda_s;
    if (stop_cond) begin
      st_d.state = EERD_IDLE;                                  // [RULE_04]
      st_d.oe    = 1'b0;                                       // [RULE_04]
    end else if (start_cond) begin
      // A repeated start drops any write but leaves the pointer intact
      st_d.state = EERD_CTRL;                                  // [RULE_06]
      st_d.cnt   = CNT_ZERO;
      st_d.oe    = 1'b0;
    end else begin
      case (st_q.state)
        EERD_IDLE: begin
          // Preload words drain into the array only in this state
          st_d.oe = 1'b0;
        end

        EERD_CTRL, EERD_WADDR: begin
          // Bits are counted on rises; the verdict falls on the eighth fall
          if (scl_rise) begin
            st_d.shreg = {st_q.shreg[DATA_W-2:0], sda_s};
            st_d.cnt   = st_q.cnt + CNT_ONE;
          end else if (scl_fall && st_q.cnt == BYTE_BITS) begin
            if (prog_busy_i) begin
              st_d.state = EERD_SKIP;                          // [RULE_12]
            end else if (st_q.state == EERD_WADDR) begin
              // Loaded before its acknowledge, so a repeated start finds it
              st_d.ptr   = st_q.shreg[ADDR_W-1:0];             // [RULE_05]
              st_d.oe    = 1'b1;
              st_d.state = EERD_WACK;
            end else if (st_q.shreg[DATA_W-1:DATA_W-4] == CTRL_CODE) begin
              st_d.rw    = st_q.shreg[0];                      // [RULE_01] [RULE_11]
              st_d.oe    = 1'b1;                               // [RULE_03]
              st_d.state = EERD_CACK;
            end else begin
              st_d.state = EERD_SKIP;                          // [RULE_11]
            end
          end
        end

        EERD_CACK, EERD_RACK: begin
          // In RACK the master's answer is taken on the rise; both states act at the fall
          if (scl_rise && st_q.state == EERD_RACK) begin
            st_d.acked = !sda_s;                               // [RULE_08]
          end else if (scl_fall) begin
            if (st_q.state == EERD_CACK && !st_q.rw) begin
              st_d.oe    = 1'b0;
              st_d.cnt   = CNT_ZERO;
              st_d.state = EERD_WADDR;                         // [RULE_01]
            end else if (st_q.state == EERD_CACK || st_q.acked) begin
              // Bit seven goes out at once; the pointer steps past the loaded byte
              st_d.shreg = mem_q[st_q.ptr];                    // [RULE_02] [RULE_03]
              st_d.ptr   = st_q.ptr + PTR_STEP;                // [RULE_09] [RULE_10]
              st_d.oe    = !mem_q[st_q.ptr][DATA_W-1];
              st_d.cnt   = CNT_ONE;
              st_d.state = EERD_TX;                            // [RULE_08]
            end else begin
              st_d.oe    = 1'b0;                               // [RULE_04]
              st_d.state = EERD_SKIP;
            end
          end
        end

        EERD_WACK: begin
          // Data bytes of a write are not handled by the read path
          if (scl_fall) begin
            st_d.oe    = 1'b0;
            st_d.state = EERD_SKIP;
          end
        end

        EERD_TX: begin
          // After the eighth bit the line is let go for the master's answer
          if (scl_fall) begin
            if (st_q.cnt == BYTE_BITS) begin
              st_d.oe    = 1'b0;
              st_d.acked = 1'b0;
              st_d.state = EERD_RACK;
            end else begin
              st_d.shreg = {st_q.shreg[DATA_W-2:0], 1'b0};
              st_d.oe    = !st_q.shreg[DATA_W-2];
              st_d.cnt   = st_q.cnt + CNT_ONE;
            end
          end
        end

        EERD_SKIP: begin
          // Foreign or refused traffic: silent until the next start or stop
          st_d.oe = 1'b0;
        end

        default: begin
          st_d.state = EERD_IDLE;
          st_d.oe    = 1'b0;
        end
      endcase
    end
    st_d.act = (st_d.state != EERD_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; bus lines idle high, so no false edge follows reset
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q          <= '0;
      st_q.scl_sync <= 2'h3;
      st_q.sda_sync <= 2'h3;
      st_q.scl_prev <= 1'b1;
      st_q.sda_prev <= 1'b1;
      st_q.state    <= EERD_IDLE;
      st_q.shreg    <= BYTE_ZERO;
      st_q.ptr      <= PTR_RESET;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- eerd_top_tb.sv
// Self-checking bench for the memory read path
`timescale 1ns/10ps
module eerd_top_tb
  import eerd_pkg::*;
;
  logic              clk_sys_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              prog_busy_i;
  logic              fill_valid_i;
  eerd_fill_s        fill_i;
  logic              sda_oe_o, sda_o, fill_ready_o, active_o, scl, pull, nak;
  logic [ADDR_W-1:0] addr_ptr_o;
  logic [7:0]        d;
  logic [7:0]        mem [MEM_WORDS];
  int                ptr, bad_count, n_tests;
  // Open-drain line: the device shows its drive value only while enabled
  wire               sda = !pull && (sda_oe_o ? sda_o : 1'b1);
  always #25 clk_sys_i = !clk_sys_i;
  eerd_top dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_busy_i(prog_busy_i), .fill_i(fill_i),
    .fill_valid_i(fill_valid_i), .fill_ready_o(fill_ready_o), .addr_ptr_o(addr_ptr_o),
    .active_o(active_o));
  eerd_master m (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rst;
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    ptr = 0;
    chk(8'(addr_ptr_o), 8'h00);
  endtask
  task automatic push(input int a);
    d = 8'($urandom);
    fill_i <= {7'(a), d};
    fill_valid_i <= 1'b1;
    do @(posedge clk_sys_i); while (fill_ready_o !== 1'b1);
    mem[a] = d;
  endtask
  task automatic ctl(input logic [3:0] code, input logic rw);
    m.cond(1'b1);
    m.put({code, 3'($urandom), rw}, nak);
    chk(8'(nak), 8'(code != CTRL_CODE || prog_busy_i));
  endtask
  task automatic seek(input int a);
    ctl(CTRL_CODE, 1'b0);
    m.put({1'($urandom), 7'(a)}, nak);
    chk(8'(nak), 8'h00);
    ptr = a;
  endtask
  task automatic rd(input int n);
    ctl(CTRL_CODE, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.get(i < n - 1, d);
      chk(d, mem[ptr]);
      ptr = (ptr + 1) % MEM_WORDS;
    end
    m.cond(1'b0);
    chk(8'(addr_ptr_o), 8'(ptr));
    chk(8'(sda_oe_o | active_o), 8'h00);
  endtask
  initial begin
    void'($urandom(32'h2c3a));
    fill_i <= '0;
    fill_valid_i <= 1'b0;
    prog_busy_i <= 1'b0;
    rst();
    // A frame keeps the FIFO from draining, so it fills to refusal
    m.cond(1'b1);
    for (int a = 0; a < MEM_WORDS; a++) begin
      if (a == FIFO_DEPTH) begin
        fill_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(8'(fill_ready_o), 8'h00);
        m.cond(1'b0);
      end
      push(a);
    end
    fill_valid_i <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    seek($urandom_range(0, 127));
    rd(1);
    rd(1);
    rd(2);
    seek(7'h7d);
    rd(5);
    for (int c = 0; c < 16; c++) begin
      ctl(4'(c), 1'b0);
      m.cond(1'b0);
    end
    prog_busy_i <= 1'b1;
    ctl(CTRL_CODE, 1'b1);
    m.cond(1'b0);
    prog_busy_i <= 1'b0;
    // A busy cycle that begins after the control byte also mutes the address ack
    ctl(CTRL_CODE, 1'b0);
    prog_busy_i <= 1'b1;
    m.put({1'($urandom), 7'($urandom)}, nak);
    chk(8'(nak), 8'h01);
    m.cond(1'b0);
    prog_busy_i <= 1'b0;
    rd(1);
    rst();
    chk(8'(fill_ready_o), 8'h01);
    close_out();
  end
  initial begin
    #2_000_000;
    bad_count++;
    close_out();
  end
endmodule
